// ==== logic/asrc_host.sv ====
// Host-side controller that drives a 32K x 8 asynchronous SRAM.
// Assumes the memory pins connect straight to the ports below.
`timescale 1ns/10ps
`include "asrc_map.svh"
module asrc_host (
   input wire logic mclk,
   input wire logic rst_b,
   input wire asrc_pkg::asrc_req_type reqData,
   input wire logic reqValid,
   output logic reqReady,
   output logic [`ASRC_DATA_W-1:0] rdData_ff,
   output logic rdValid_ff,
   input wire logic retainReq,
   output logic retainAck,
   output logic [`ASRC_ADDR_W-1:0] address_bus_ff,
   output asrc_pkg::asrc_strobe_type strobe_ff,
   input wire logic [`ASRC_DATA_W-1:0] dataIoIn,
   output logic [`ASRC_DATA_W-1:0] dataIoOut_ff,
   output logic dataIoOe_ff
);
   import asrc_pkg::*;

   asrc_state_type state_ff, nxt_state;
   logic [3:0] cnt_ff;
   logic [3:0] cycCnt_ff;
   logic [`ASRC_DATA_W-1:0] dataSync;
   logic cntDone;

   function automatic logic [3:0] ticks(input int n);
      ticks = (n < 1) ? 4'h1 : 4'(n);
   endfunction

   // Pin data crosses from the memory's asynchronous output
   asrc_sync #(.W(`ASRC_DATA_W)) uSync (
      .mclk(mclk),
      .rst_b(rst_b),
      .din(dataIoIn),
      .dout(dataSync)
   );

   assign cntDone = (cnt_ff <= 4'h1);
   assign reqReady = (state_ff == S_IDLE) && !retainReq
      && (cycCnt_ff == 4'h0);
   assign retainAck = (state_ff == S_RETAIN);

   // Retention pins frozen; a drifting line would cost retention current
   a_retain_desel: assert property (
      @(posedge mclk) disable iff (!rst_b)
      retainAck |-> strobe_ff.selB && !dataIoOe_ff)
      else $error("Retention without deselect");
   a_retain_static: assert property (
      @(posedge mclk) disable iff (!rst_b)
      retainAck && $past(retainAck) |-> $stable(address_bus_ff)
         && $stable(strobe_ff) && $stable(dataIoOut_ff))
      else $error("Pins moved during retention");
   a_retain_entry: assert property (
      @(posedge mclk) disable iff (!rst_b)
      $rose(retainAck) |-> $past(strobe_ff.selB) && !$past(dataIoOe_ff))
      else $error("Retention entered from an open access");
   a_recovery_gap: assert property (
      @(posedge mclk) disable iff (!rst_b)
      $fell(retainAck) |-> !reqReady)
      else $error("Access allowed straight after retention");

   always_comb begin
      nxt_state = state_ff;
      case (state_ff)
         S_IDLE: begin
            if (retainReq) begin
               nxt_state = S_RETAIN;
            end else if (reqValid && reqReady) begin
               nxt_state = reqData.wr ? S_WSETUP : S_RD;
            end
         end
         S_RD: if (cntDone) nxt_state = S_RDSAMP;
         S_RDSAMP: nxt_state = S_FLOAT;
         S_WSETUP: nxt_state = S_WPULSE;
         S_WPULSE: if (cntDone) nxt_state = S_FLOAT;
         S_FLOAT: if (cntDone) nxt_state = S_IDLE;
         S_RETAIN: if (!retainReq) nxt_state = S_FLOAT;
         default: nxt_state = S_IDLE;
      endcase
   end

   always_ff @(posedge mclk or negedge rst_b) begin
      if (!rst_b) state_ff <= S_IDLE;
      else state_ff <= nxt_state;
   end

   // Per-state dwell counter
   always_ff @(posedge mclk or negedge rst_b) begin
      if (!rst_b) begin
         cnt_ff <= 4'h0;
      end else if (state_ff != nxt_state) begin
         case (nxt_state)
            // Sync adds three edges before pin data is trustworthy
            S_RD: cnt_ff <= ticks(`ASRC_ACC_CNT) + 4'h3;
            S_WPULSE: cnt_ff <= ticks(`ASRC_WPW_CNT);
            S_FLOAT: cnt_ff <= ticks(`ASRC_FLOAT_CNT);
            default: cnt_ff <= 4'h0;
         endcase
      end else if (cnt_ff != 4'h0) begin
         cnt_ff <= cnt_ff - 4'h1;
      end
   end

   // Least spacing between access starts
   always_ff @(posedge mclk or negedge rst_b) begin
      if (!rst_b) begin
         cycCnt_ff <= 4'h0;
      end else if (reqValid && reqReady) begin
         cycCnt_ff <= ticks(`ASRC_CYC_CNT);
      end else if (state_ff == S_RETAIN) begin
         cycCnt_ff <= ticks(`ASRC_CYC_CNT);
      end else if (cycCnt_ff != 4'h0) begin
         cycCnt_ff <= cycCnt_ff - 4'h1;
      end
   end

   // Strobes; select stays high whenever idle for standby
   always_ff @(posedge mclk or negedge rst_b) begin
      if (!rst_b) begin
         strobe_ff <= '{selB: 1'b1, outEnB: 1'b1, wrEnB: 1'b1};
      end else begin
         case (nxt_state)
            S_RD, S_RDSAMP: begin
               strobe_ff <= '{selB: 1'b0, outEnB: 1'b0, wrEnB: 1'b1};
            end
            S_WSETUP: begin
               // Output enable kept high so the memory never drives
               strobe_ff <= '{selB: 1'b0, outEnB: 1'b1, wrEnB: 1'b1};
            end
            S_WPULSE: begin
               strobe_ff <= '{selB: 1'b0, outEnB: 1'b1, wrEnB: 1'b0};
            end
            default: begin
               strobe_ff <= '{selB: 1'b1, outEnB: 1'b1, wrEnB: 1'b1};
            end
         endcase
      end
   end

   // Write pulse: select and data held through the low phase
   sequence s_wr_pulse;
      !strobe_ff.wrEnB && !strobe_ff.selB && dataIoOe_ff;
   endsequence
   sequence s_wr_release;
      strobe_ff.wrEnB && dataIoOe_ff && $stable(dataIoOut_ff);
   endsequence
   a_write_pulse: assert property (
      @(posedge mclk) disable iff (!rst_b)
      $fell(strobe_ff.wrEnB) |-> s_wr_pulse [*1] ##1 s_wr_release)
      else $error("Write pulse malformed");
   a_write_sel_low: assert property (
      @(posedge mclk) disable iff (!rst_b)
      !strobe_ff.wrEnB |-> !strobe_ff.selB)
      else $error("Write strobe without select");
   a_idle_standby: assert property (
      @(posedge mclk) disable iff (!rst_b)
      reqReady |-> strobe_ff.selB && strobe_ff.wrEnB && !dataIoOe_ff)
      else $error("Access lines busy while ready");
   a_float_gap: assert property (
      @(posedge mclk) disable iff (!rst_b)
      $rose(strobe_ff.outEnB) |-> !reqReady)
      else $error("New access before bus floats");

   // Address moves only while the write strobe is high; select falls on the same edge
   always_ff @(posedge mclk or negedge rst_b) begin
      if (!rst_b) begin
         address_bus_ff <= '0;
      end else if (reqValid && reqReady) begin
         address_bus_ff <= reqData.addr;
      end
   end

   a_addr_stable_wr: assert property (
      @(posedge mclk) disable iff (!rst_b)
      !strobe_ff.wrEnB |-> $stable(address_bus_ff))
      else $error("Address moved during write strobe");

   // Data drive spans setup, pulse and one edge past write rise
   always_ff @(posedge mclk or negedge rst_b) begin
      if (!rst_b) begin
         dataIoOut_ff <= '0;
         dataIoOe_ff <= 1'b0;
      end else begin
         if (reqValid && reqReady && reqData.wr) begin
            dataIoOut_ff <= reqData.wdata;
         end
         dataIoOe_ff <= (nxt_state == S_WSETUP) || (nxt_state == S_WPULSE)
            || (state_ff == S_WPULSE);
      end
   end

   a_no_contention: assert property (
      @(posedge mclk) disable iff (!rst_b)
      dataIoOe_ff |-> strobe_ff.outEnB)
      else $error("Host drives while memory outputs enabled");
   a_data_setup_wr: assert property (
      @(posedge mclk) disable iff (!rst_b)
      $fell(strobe_ff.wrEnB) |-> $past(dataIoOe_ff) && $stable(dataIoOut_ff))
      else $error("Write data not set up before strobe");
   a_data_hold_wr: assert property (
      @(posedge mclk) disable iff (!rst_b)
      $rose(strobe_ff.wrEnB) |-> dataIoOe_ff && $stable(dataIoOut_ff))
      else $error("Write data not held past write rise");

   // Read capture
   always_ff @(posedge mclk or negedge rst_b) begin
      if (!rst_b) begin
         rdData_ff <= '0;
         rdValid_ff <= 1'b0;
      end else begin
         rdValid_ff <= (state_ff == S_RDSAMP);
         if (state_ff == S_RDSAMP) begin
            rdData_ff <= dataSync;
         end
      end
   end

   a_read_mode: assert property (
      @(posedge mclk) disable iff (!rst_b)
      rdValid_ff |-> $past(!strobe_ff.outEnB) && $past(strobe_ff.wrEnB))
      else $error("Read capture outside read mode");
endmodule

// ==== logic/asrc_map.svh ====
// Timing constants and field layout for the async SRAM host controller.
// Assumes a 10 MHz mclk and one of two memory speed grades.
// Summary of operation
// - Address changes only while write strobe high
// - Host drives data only after outputs float
// - Data set up before write rises, held after
// - Each cycle lasts at least one cycle time
// - Write strobe low for the pulse width
// - Address stable before the terminating edge
// - Select-controlled write holds select low long enough
// - Address may change at strobe edges
// - Retention: select high, inputs held static
// - Wait one cycle time after supply recovery
// - Deselect before the supply drops
`ifndef ASRC_MAP_SVH
`define ASRC_MAP_SVH
`define ASRC_ADDR_W 15
`define ASRC_DATA_W 8
`define ASRC_CLK_NS 100
`define ASRC_CYC_NS 20
`define ASRC_ACC_NS 20
`define ASRC_OEACC_NS 10
`define ASRC_FLOAT_NS 10
`define ASRC_WLQZ_NS 10
`define ASRC_WPW_NS 12
`define ASRC_EPW_NS 15
`define ASRC_DSU_NS 10
`define ASRC_CEIL(t) (((t) + `ASRC_CLK_NS - 1) / `ASRC_CLK_NS)
`define ASRC_CYC_CNT `ASRC_CEIL(`ASRC_CYC_NS)
`define ASRC_ACC_CNT `ASRC_CEIL(`ASRC_ACC_NS)
`define ASRC_FLOAT_CNT `ASRC_CEIL(`ASRC_FLOAT_NS)
`define ASRC_WPW_CNT `ASRC_CEIL(`ASRC_WPW_NS)
`endif

// ==== logic/asrc_pkg.sv ====
// Types for the async SRAM host controller.
// Assumes asrc_map.svh is on the include path.
`include "asrc_map.svh"
package asrc_pkg;
   typedef struct packed {
      logic wr;
      logic [`ASRC_ADDR_W-1:0] addr;
      logic [`ASRC_DATA_W-1:0] wdata;
   } asrc_req_type;
   typedef struct packed {
      logic selB;
      logic outEnB;
      logic wrEnB;
   } asrc_strobe_type;
   typedef enum logic [2:0] {
      S_IDLE, S_RD, S_RDSAMP, S_WSETUP, S_WPULSE, S_FLOAT, S_RETAIN
   } asrc_state_type;
endpackage

// ==== logic/asrc_sync.sv ====
// Three-stage synchroniser for pins from outside the mclk domain.
// Output changes once the second and third stages agree.
`timescale 1ns/10ps
module asrc_sync #(parameter int W = 8) (
   input wire logic mclk,
   input wire logic rst_b,
   input wire logic [W-1:0] din,
   output logic [W-1:0] dout
);
   logic [W-1:0] s1_ff, s2_ff, s3_ff;
   always_ff @(posedge mclk or negedge rst_b) begin
      if (!rst_b) begin
         s1_ff <= '0;
         s2_ff <= '0;
         s3_ff <= '0;
      end else begin
         s1_ff <= din;
         s2_ff <= s1_ff;
         s3_ff <= s2_ff;
      end
   end
   always_ff @(posedge mclk or negedge rst_b) begin
      if (!rst_b) begin
         dout <= '0;
      end else begin
         for (int i = 0; i < W; i++) begin
            if (s2_ff[i] == s3_ff[i]) begin
               dout[i] <= s3_ff[i];
            end
         end
      end
   end
endmodule

// ==== tb/asrc_host_tb_top.sv ====
// Self-checking bench for the async SRAM host controller.
// Assumes asrc_sram_model sits on the memory pins.
`timescale 1ns/10ps
module asrc_host_tb_top;
   import asrc_pkg::*;
   logic mclk, rst_b, reqValid, reqReady, rdValid_ff, retainReq;
   logic retainAck, dataIoOe_ff, slow, memDrive;
   asrc_req_type reqData;
   asrc_strobe_type strobe_ff;
   logic [7:0] rdData_ff, dataIoIn, dataIoOut_ff, memOut;
   logic [14:0] address_bus_ff;
   int errCount = 0, samplesChecked = 0, cyc = 0, seed = 32'h8681;
   int refMem [int];
   int a, d;
   assign dataIoIn = dataIoOe_ff ? dataIoOut_ff : memOut;
   asrc_host i_dut (.mclk(mclk), .rst_b(rst_b), .reqData(reqData),
      .reqValid(reqValid), .reqReady(reqReady), .rdData_ff(rdData_ff),
      .rdValid_ff(rdValid_ff), .retainReq(retainReq),
      .retainAck(retainAck), .address_bus_ff(address_bus_ff),
      .strobe_ff(strobe_ff), .dataIoIn(dataIoIn),
      .dataIoOut_ff(dataIoOut_ff), .dataIoOe_ff(dataIoOe_ff));
   asrc_sram_model i_mem (.slow(slow), .addr(address_bus_ff),
      .stb(strobe_ff), .dIn(dataIoIn), .dOut(memOut), .drive(memDrive));
   initial begin
      mclk = 1'b0;
      forever #50 mclk = ~mclk;
   end
   task automatic check(input logic [7:0] seen, exp, input string what);
      samplesChecked++;
      if (seen !== exp) begin
         errCount++;
         $display("Error %s expected %h seen %h", what, exp, seen);
      end
   endtask
   task automatic wrapUp;
      $display("checks %0d mismatches %0d", samplesChecked, errCount);
      if (errCount == 0 && samplesChecked > 0) begin
         $display("bench passed");
      end else begin
         $display("bench failed");
      end
      $finish;
   endtask
   // Holds the request until the edge that takes it
   task automatic op(input logic w, input int ad, input int dt);
      int n;
      n = 0;
      @(posedge mclk);
      reqData <= '{w, ad[14:0], dt[7:0]};
      reqValid <= 1'b1;
      @(posedge mclk);
      while (reqReady !== 1'b1 && n < 60) begin
         @(posedge mclk);
         n++;
      end
      check({7'h00, reqReady}, 8'h01, "request taken");
      reqValid <= 1'b0;
      if (w) begin
         refMem[ad] = dt;
      end else begin
         while (rdValid_ff !== 1'b1 && n < 120) begin
            @(posedge mclk);
            n++;
         end
         check({7'h00, rdValid_ff}, 8'h01, "read answer");
         check(rdData_ff, 8'(refMem[ad]), "read data");
         check({5'h00, strobe_ff}, 8'h07, "idle strobes");
      end
   endtask
   always @(posedge mclk) begin
      cyc++;
      if (rst_b === 1'b1) begin
         check({7'h00, dataIoOe_ff & memDrive}, 8'h00, "contention");
         check({7'h00, retainAck & ~strobe_ff.selB}, 8'h00, "standby");
      end
      // Slack well above the longest test
      if (cyc == 4000) begin
         errCount++;
         wrapUp();
      end
   end
   initial begin
      rst_b = 1'b0;
      reqValid = 1'b0;
      retainReq = 1'b0;
      slow = 1'b1;
      reqData = '0;
      repeat (12) @(posedge mclk);
      check({5'h00, strobe_ff}, 8'h07, "reset strobes");
      check({7'h00, dataIoOe_ff}, 8'h00, "reset drive");
      rst_b <= 1'b1;
      op(1'b1, 0, 8'h5a);
      op(1'b1, 32'h7fff, 8'ha5);
      op(1'b0, 0, 0);
      op(1'b0, 32'h7fff, 0);
      $display("test boundary done");
      for (int i = 0; i < 16; i++) begin
         a = $random(seed) & 32'h7fff;
         d = $random(seed) & 32'hff;
         slow <= i[0];
         op(1'b1, a, d);
         op(1'b1, a, ~d);
         op(1'b0, a, 0);
      end
      $display("test random done");
      retainReq <= 1'b1;
      fork
         op(1'b0, 0, 0);
         begin
            repeat (10) @(posedge mclk);
            check({7'h00, retainAck}, 8'h01, "retain ack");
            check({7'h00, rdValid_ff}, 8'h00, "refused read");
            retainReq <= 1'b0;
            @(posedge mclk);
            check({7'h00, reqReady}, 8'h00, "recovery gap");
         end
      join
      $display("test retention done");
      wrapUp();
   end
endmodule

// ==== tb/asrc_sram_model.sv ====
// Behavioural 32K x 8 async SRAM on the host pins.
// Assumes the bench resolves the shared data pins.
`timescale 1ns/10ps
`include "asrc_map.svh"
module asrc_sram_model (
   input wire logic slow,
   input wire logic [`ASRC_ADDR_W-1:0] addr,
   input wire asrc_pkg::asrc_strobe_type stb,
   input wire logic [`ASRC_DATA_W-1:0] dIn,
   output logic [`ASRC_DATA_W-1:0] dOut,
   output logic drive
);
   import asrc_pkg::*;
   logic [7:0] mem [0:32767];
   logic [7:0] last = 8'h00;
   logic ready = 1'b0;
   logic writing;
   // Write or deselect floats at once
   assign drive = !stb.selB && !stb.outEnB && stb.wrEnB;
   assign writing = !stb.selB && !stb.wrEnB;
   // Worst case of the slow grade, else a 7 ns fast-grade figure
   always @(addr or stb) begin
      ready = 1'b0;
      #(slow ? 20 : 7);
      ready = 1'b1;
      if (drive) begin
         last = mem[addr];
      end
   end
   // Never a kept value on a floating bus
   assign dOut = (drive && ready) ? mem[addr] : ~last;
   always @(negedge writing) begin
      mem[addr] = dIn;
   end
endmodule
